// ==== nvmem_host_pkg.sv ====
// Package for the host-side controller of an asynchronous nonvolatile SRAM.
// Assumes a single 10 MHz reference clock shared by all users of the package.
package nvmem_host_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  // Read cycle time of the slowest speed grade.
  localparam int unsigned CYCLE_TIME_NS = 45;
  localparam int unsigned CYCLE_CLKS =
    (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest store, industrial grade, and power-up restore.
  localparam int unsigned SAVE_DURATION_US    = 15000;
  localparam int unsigned RESTORE_DURATION_US = 20000;
  localparam int unsigned SAVE_CLKS    = SAVE_DURATION_US * 10;
  localparam int unsigned RESTORE_CLKS = RESTORE_DURATION_US * 10;
  localparam int unsigned SEQ_LEN = 6;

  localparam logic [13:0] SEQ_A0 = 14'h0e38;
  localparam logic [13:0] SEQ_A1 = 14'h31c7;
  localparam logic [13:0] SEQ_A2 = 14'h03e0;
  localparam logic [13:0] SEQ_A3 = 14'h3c1f;
  localparam logic [13:0] SEQ_A4 = 14'h303f;
  localparam logic [13:0] SEQ_SAVE    = 14'h0fc0;
  localparam logic [13:0] SEQ_RESTORE = 14'h0c63;

  typedef enum logic [1:0] {
    CMD_READ    = 2'b00,
    CMD_WRITE   = 2'b01,
    CMD_SAVE    = 2'b10,
    CMD_RESTORE = 2'b11
  } cmd_e;

  typedef struct packed {
    cmd_e        cmd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } req_s;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [14:0] addr;
  } mem_ctl_s;

  function automatic logic [13:0] seq_addr(input logic [2:0] step,
                                           input logic save);
    case (step)
      3'd0: seq_addr = SEQ_A0;
      3'd1: seq_addr = SEQ_A1;
      3'd2: seq_addr = SEQ_A2;
      3'd3: seq_addr = SEQ_A3;
      3'd4: seq_addr = SEQ_A4;
      default: seq_addr = save ? SEQ_SAVE : SEQ_RESTORE;
    endcase
  endfunction : seq_addr

endpackage : nvmem_host_pkg

// ==== nvmem_host.sv ====
// Host controller that drives an asynchronous nonvolatile SRAM by its pins.
// Assumes the memory pins are sampled on ref_clk and the power-fail level
// is already synchronous.
`timescale 1ns/1ps
`default_nettype none

module nvmem_host #(
  parameter int unsigned SAVE_WAIT    = nvmem_host_pkg::SAVE_CLKS,
  parameter int unsigned RESTORE_WAIT = nvmem_host_pkg::RESTORE_CLKS
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  // Request side
  input  wire logic                     req_valid,
  input  wire nvmem_host_pkg::req_s     req,
  input  wire logic                     power_fail_level,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic [7:0]                    rsp_data,
  // Memory pins
  output var nvmem_host_pkg::mem_ctl_s  mem_ctl,
  output logic                          hw_save_req_n,
  input  wire logic [7:0]               dq_in,
  output logic [7:0]                    dq_out,
  output logic                          dq_oe
);
  import nvmem_host_pkg::*;

  typedef enum logic [2:0] {
    ST_BOOT   = 3'b000,
    ST_IDLE   = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_END    = 3'b100,
    ST_WAIT   = 3'b101
  } state_e;

  state_e      state, next_state;
  req_s        cur, next_cur;
  logic [2:0]  step, next_step;
  logic [17:0] cnt, next_cnt;
  mem_ctl_s    next_mem_ctl;
  logic        next_req_ready, next_rsp_valid, next_dq_oe;
  logic [7:0]  next_rsp_data, next_dq_out;
  logic        seq_cmd;

  assign seq_cmd = (cur.cmd == CMD_SAVE) || (cur.cmd == CMD_RESTORE);

  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_step      = step;
    next_cnt       = cnt;
    next_mem_ctl   = mem_ctl;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    next_dq_out    = dq_out;
    next_dq_oe     = 1'b0;
    case (state)
      ST_BOOT: begin
        next_mem_ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
        if (!power_fail_level) begin
          next_cnt = cnt + 18'd1;
        end else begin
          next_cnt = '0;
        end
        if (cnt >= 18'(RESTORE_WAIT)) begin
          next_state     = ST_IDLE;
          next_req_ready = 1'b1;
        end
      end
      ST_IDLE: begin
        next_req_ready = 1'b1;
        next_cnt = '0;
        if (power_fail_level) begin
          next_state     = ST_BOOT;
          next_req_ready = 1'b0;
        end else if (req_valid) begin
          next_cur       = req;
          next_req_ready = 1'b0;
          next_step      = 3'd0;
          next_state     = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Address settles with select high so select falls last.
        next_mem_ctl.ce_n = 1'b1;
        next_mem_ctl.we_n = 1'b1;
        next_mem_ctl.oe_n = (cur.cmd == CMD_WRITE);
        if (seq_cmd) begin
          next_mem_ctl.addr = {1'b0, seq_addr(step, cur.cmd == CMD_SAVE)};
        end else begin
          next_mem_ctl.addr = cur.addr;
        end
        next_dq_out = cur.wdata;
        next_cnt    = '0;
        next_state  = ST_STROBE;
      end
      ST_STROBE: begin
        next_mem_ctl.ce_n = 1'b0;
        // Strobe drops only after select, never before it.
        next_mem_ctl.we_n = !((cur.cmd == CMD_WRITE) && !mem_ctl.ce_n);
        next_dq_oe        = (cur.cmd == CMD_WRITE);
        next_cnt          = cnt + 18'd1;
        if (cnt >= 18'(CYCLE_CLKS)) begin
          next_state    = ST_END;
          next_rsp_data = dq_in;
        end
      end
      ST_END: begin
        next_mem_ctl.ce_n = 1'b1;
        next_mem_ctl.we_n = 1'b1;
        next_mem_ctl.oe_n = 1'b1;
        next_dq_oe        = 1'b0;
        next_cnt          = '0;
        if (seq_cmd && step != 3'(SEQ_LEN - 1)) begin
          next_step  = step + 3'd1;
          next_state = ST_SETUP;
        end else if (seq_cmd) begin
          next_state = ST_WAIT;
        end else begin
          next_rsp_valid = 1'b1;
          next_req_ready = 1'b1;
          next_state     = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // Waiting the full time is safe even when a save is skipped.
        next_cnt = cnt + 18'd1;
        if (cnt >= 18'((cur.cmd == CMD_SAVE) ? SAVE_WAIT : RESTORE_WAIT)) begin
          next_step      = 3'd0;
          next_rsp_valid = 1'b1;
          next_req_ready = 1'b1;
          next_state     = ST_IDLE;
        end
      end
      default: next_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_BOOT;
      cur       <= '0;
      step      <= 3'd0;
      cnt       <= '0;
      mem_ctl   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      dq_out    <= 8'h00;
      dq_oe     <= 1'b0;
      hw_save_req_n <= 1'b1;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      step      <= next_step;
      cnt       <= next_cnt;
      mem_ctl   <= next_mem_ctl;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      dq_out    <= next_dq_out;
      dq_oe     <= next_dq_oe;
      // The hardware request pin is never used, so it idles high.
      hw_save_req_n <= 1'b1;
    end
  end

  a_read_we_high: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!mem_ctl.oe_n && !mem_ctl.ce_n) |-> mem_ctl.we_n)
    else $error("Write strobe low during a read.");
  a_hsb_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !mem_ctl.ce_n |-> hw_save_req_n)
    else $error("Save request low during an access.");
  a_we_after_ce: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(mem_ctl.we_n) |-> !$past(mem_ctl.ce_n))
    else $error("Strobe fell before select.");
  a_no_access_pf: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_BOOT || state == ST_WAIT) |-> mem_ctl.ce_n)
    else $error("Access issued while busy.");
  a_boot_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_BOOT && cnt < 18'(RESTORE_WAIT)) |=> state != ST_IDLE)
    else $error("Left power-up wait early.");
  a_cmd_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_STROBE && seq_cmd) |->
      mem_ctl.addr == {1'b0, seq_addr(step, cur.cmd == CMD_SAVE)})
    else $error("Command address out of order.");
  a_seq_we_high: assert property (@(posedge ref_clk) disable iff (!nrst)
    (seq_cmd && state != ST_IDLE) |-> mem_ctl.we_n)
    else $error("Strobe low inside a command.");
  a_cycle_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(mem_ctl.ce_n) |-> !mem_ctl.ce_n [*2])
    else $error("Select pulse too short.");
  a_top_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_STROBE && seq_cmd) |-> !mem_ctl.addr[14])
    else $error("Top address bit set in a command.");
  c_read: cover property (@(posedge ref_clk) disable iff (!nrst)
    rsp_valid && cur.cmd == CMD_READ);
  c_write: cover property (@(posedge ref_clk) disable iff (!nrst)
    rsp_valid && cur.cmd == CMD_WRITE);
  c_save: cover property (@(posedge ref_clk) disable iff (!nrst)
    state == ST_WAIT && cur.cmd == CMD_SAVE);
  c_restore: cover property (@(posedge ref_clk) disable iff (!nrst)
    state == ST_WAIT && cur.cmd == CMD_RESTORE);

endmodule : nvmem_host

`default_nettype wire

// ==== nvsram_model.sv ====
// Behavioural nonvolatile static memory driven through its host pins.
// Assumes the pins come from nvmem_host and no pull exists on the data bus.
`timescale 1ns/1ps
`default_nettype none
module nvsram_model #(
  parameter int SAVE_NS   = 1500,
  parameter int RECALL_NS = 2500
) (
  // Host pins
  input  wire nvmem_host_pkg::mem_ctl_s ctl,
  input  wire logic [7:0]               dq_out,
  input  wire logic                     power_fail_level,
  output logic [7:0]                    dq_in
);
  import nvmem_host_pkg::*;
  localparam logic [13:0] STEPS [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3,
                                        SEQ_A4};
  logic [7:0] mem    [32768];
  logic [7:0] shadow [32768];
  logic [7:0] last  = 8'h00;
  logic       busy  = 1'b0;
  logic       dirty = 1'b0;
  logic       wsel  = 1'b0;
  int         step  = 0;
  wire        wr    = !ctl.ce_n && !ctl.we_n;
  wire        drv   = !ctl.ce_n && !ctl.oe_n && ctl.we_n && !wsel &&
                      !busy && !power_fail_level;
  // A released bus shows the inverse of its last value, never a held copy.
  assign dq_in = drv ? mem[ctl.addr] : ~last;
  always @(dq_in) if (drv) last = dq_in;

  task automatic hold_busy(input int ns);
    busy = 1'b1;
    #(ns);
    busy = 1'b0;
    step = 0;
  endtask : hold_busy

  always @(negedge ctl.ce_n) begin
    wsel = !ctl.we_n;
    if (ctl.we_n && !busy && !power_fail_level) begin
      if (step == 5 && ctl.addr[13:0] == SEQ_SAVE) begin
        if (dirty) shadow = mem;
        dirty = 1'b0;
        hold_busy(SAVE_NS);
      end else if (step == 5 && ctl.addr[13:0] == SEQ_RESTORE) begin
        mem = shadow;
        dirty = 1'b0;
        hold_busy(RECALL_NS);
      end else if (step < 5 && ctl.addr[13:0] == STEPS[step]) step++;
      else step = (ctl.addr[13:0] == STEPS[0]) ? 1 : 0;
    end
  end

  always @(negedge wr) if (!busy && !power_fail_level) begin
    mem[ctl.addr] = dq_out;
    dirty = 1'b1;
    step = 0;
  end

  always @(negedge power_fail_level) begin
    mem = shadow;
    hold_busy(RECALL_NS);
  end
endmodule : nvsram_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for nvmem_host against a behavioural memory.
// Assumes the package, the design and nvsram_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import nvmem_host_pkg::*;
  localparam int SW = 20;
  localparam int RW = 30;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       req_valid = 1'b0;
  logic       power_fail_level = 1'b0;
  req_s       req = '0;
  logic       req_ready, rsp_valid, hw_save_req_n, dq_oe;
  logic [7:0] rsp_data, dq_in, dq_out, rd;
  mem_ctl_s   mem_ctl;
  int         failures = 0;
  int         checks = 0;
  int         n;
  int         quiet = 0;
  logic [14:0] seen [$];

  always #50 ref_clk = ~ref_clk;

  nvmem_host #(.SAVE_WAIT(SW), .RESTORE_WAIT(RW)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .power_fail_level(power_fail_level), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_ctl(mem_ctl),
    .hw_save_req_n(hw_save_req_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe));
  nvsram_model mem_dev (.ctl(mem_ctl), .dq_out(dq_out),
    .power_fail_level(power_fail_level), .dq_in(dq_in));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  always @(negedge mem_ctl.ce_n) if (nrst) seen.push_back(mem_ctl.addr);
  // Counts cycles since select was last low, to time the busy wait.
  always @(posedge ref_clk) quiet <= mem_ctl.ce_n ? quiet + 1 : 0;
  always @(posedge ref_clk) if (nrst && dq_oe) begin
    chk(16'(mem_ctl.oe_n), 16'h0001);
    chk(16'(mem_ctl.ce_n), 16'h0000);
  end
  always @(posedge ref_clk) if (nrst && !mem_ctl.oe_n) begin
    chk(16'(mem_ctl.we_n), 16'h0001);
    chk(16'(hw_save_req_n), 16'h0001);
  end

  task automatic wait_ready(output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end while (req_ready !== 1'b1 && cnt < 100);
    chk(16'(req_ready), 16'h0001);
  endtask : wait_ready

  // The bound of 100 cycles covers the longest busy wait set here, the restore wait.
  task automatic op(input cmd_e c, input logic [14:0] a,
                    input logic [7:0] d);
    wait_ready(n);
    @(posedge ref_clk);
    req <= '{c, a, d};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    chk(16'(rsp_valid), 16'h0001);
    rd = rsp_data;
  endtask : op

  task automatic t_rw;
    op(CMD_WRITE, 15'h1234, 8'h5a);
    op(CMD_WRITE, 15'h4001, 8'ha5);
    op(CMD_READ, 15'h1234, 8'h00);
    chk(16'(rd), 16'h005a);
    op(CMD_READ, 15'h4001, 8'h00);
    chk(16'(rd), 16'h00a5);
    $display("t_rw done");
  endtask : t_rw

  task automatic t_save_restore;
    logic [13:0] exp [7] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f,
                             14'h303f, 14'h0fc0, 14'h0c63};
    op(CMD_WRITE, 15'h0100, 8'h3c);
    seen.delete();
    op(CMD_SAVE, 15'h0000, 8'h00);
    chk(16'(n > SW), 16'h0001);
    chk(16'(quiet > SW), 16'h0001);
    chk(16'(seen.size()), 16'h0006);
    for (int i = 0; i < 6; i++) chk(16'(seen[i]), 16'(exp[i]));
    op(CMD_WRITE, 15'h0100, 8'hc3);
    seen.delete();
    op(CMD_RESTORE, 15'h0000, 8'h00);
    chk(16'(quiet > RW), 16'h0001);
    chk(16'(seen.size()), 16'h0006);
    for (int i = 0; i < 6; i++) chk(16'(seen[i]), 16'(exp[i + (i == 5)]));
    op(CMD_READ, 15'h0100, 8'h00);
    chk(16'(rd), 16'h003c);
    $display("t_save_restore done");
  endtask : t_save_restore

  task automatic t_pfail;
    wait_ready(n);
    @(posedge ref_clk);
    power_fail_level <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(16'(req_ready), 16'h0000);
    @(posedge ref_clk);
    power_fail_level <= 1'b0;
    wait_ready(n);
    chk(16'(n > RW), 16'h0001);
    op(CMD_READ, 15'h0100, 8'h00);
    chk(16'(rd), 16'h003c);
    $display("t_pfail done");
  endtask : t_pfail

  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_ready(n);
    chk(16'(n > RW), 16'h0001);
    $display("t_boot done");
    t_rw;
    t_save_restore;
    t_pfail;
    complete_run;
  end

  initial begin
    #200000;
    failures++;
    complete_run;
  end
endmodule : tb
`default_nettype wire
